// File: logic/tf_device.sv
// card end: task file control registers, progress flags and interrupt request
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps

// Overview of operation
// - upper address byte holds high cylinder/block bits
// - drive/head bit 6 selects linear addressing
// - drive/head bit 4 selects master or slave
// - drive/head bits 3-0 give head/block top
// - host writes ones to obsolete bits
// - status read drops level interrupt in I/O
// - busy flag set during internal operation
// - media commands need ready and seek complete
// - write fault flag follows fault condition
// - data request flag, cleared by new command
// - corrected-data flag on corrected error
// - index flag always reads zero
// - error flag set on failure, cleared next command
// - alternate status mirrors, leaves interrupt alone
// - host writes parameters, then command when ready
// - soft reset bit holds task file reset
// - control bit 1 disables interrupt, active low
// - host writes bit3 one, bit0 zero
// - drive echo read-only, bit 7 undriven
// - echo write gate zero, inverted head bits
// - echo drive select bits low when selected
// - host avoids mapping the drive echo; this host still reads it, with bit 7 read as zero
module tf_device
  import tf_pkg::*;
#(
  parameter logic DRIVE_NUM = 1'b0
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  tf_link_if.dev          link,
  input  wire logic       io_mode_i,
  input  wire logic       level_irq_i,
  input  wire logic       ready_i,
  input  wire logic       seek_done_i,
  input  wire logic       write_fault_i,
  input  wire logic       data_req_set_i,
  input  wire logic       data_req_clr_i,
  input  wire logic       corrected_i,
  input  wire logic       op_done_i,
  input  wire logic       op_error_i,
  output logic            cmd_valid_o,
  output logic      [7:0] cmd_code_o,
  output logic      [7:0] cyl_high_o,
  output logic      [3:0] head_o,
  output logic            linear_addressing_flag_o,
  output logic            drive_select_bit_o,
  output logic            soft_reset_bit_o
);

  // register storage
  logic [7:0] cylinder_upper_byte;
  logic [7:0] drive_head_select;
  logic       soft_reset_bit;
  logic       interrupt_disable_bit;

  // progress flags held here
  logic busy_flag;
  logic data_request_flag;
  logic corrected_data_flag;
  logic error_flag;
  logic irq_pending;
  logic next_irq_pending;

  // decoded strobes
  logic rd_status;
  logic rd_alt;
  logic rd_echo;
  logic wr_cmd;
  logic wr_ctl;
  logic wr_cyl;
  logic wr_dh;
  logic cmd_allowed;
  logic cmd_accept;
  logic cmd_reject;

  // packed bytes
  logic [7:0] command_progress_flags;
  logic [7:0] legacy_drive_echo;
  logic       drive_ready_flag;
  logic       selected;

  assign rd_status = link.rd && (link.reg_sel == SEL_STATUS_CMD);
  assign rd_alt    = link.rd && (link.reg_sel == SEL_ALT_DEVCTL);
  assign rd_echo   = link.rd && (link.reg_sel == SEL_DRIVE_ADDR);
  assign wr_cmd    = link.wr && (link.reg_sel == SEL_STATUS_CMD);
  assign wr_ctl    = link.wr && (link.reg_sel == SEL_ALT_DEVCTL);
  assign wr_cyl    = link.wr && (link.reg_sel == SEL_CYL_HIGH);
  assign wr_dh     = link.wr && (link.reg_sel == SEL_DRIVE_HEAD);

  // ready drops while held in soft reset
  assign drive_ready_flag = ready_i && !soft_reset_bit;
  assign selected = (drive_head_select[DH_DRIVE] == DRIVE_NUM);

  // command admission: idle, selected, and media class needs ready and seek done
  assign cmd_allowed = wr_cmd && !busy_flag && !soft_reset_bit && selected;
  assign cmd_reject  = cmd_allowed && is_media_cmd(link.dd)
                       && !(drive_ready_flag && seek_done_i);
  assign cmd_accept  = cmd_allowed && !cmd_reject;

  // flag and echo byte packing
  tf_flag_pack #(
    .DRIVE_NUM (DRIVE_NUM)
  ) u_pack (
    .busy_i   (busy_flag || soft_reset_bit),
    .ready_i  (drive_ready_flag),
    .fault_i  (write_fault_i),
    .seek_i   (seek_done_i),
    .dreq_i   (data_request_flag),
    .corrected_data_flag_i   (corrected_data_flag),
    .err_i    (error_flag),
    .head_i   (drive_head_select[DH_HEAD_MSB:0]),
    .drive_i  (drive_head_select[DH_DRIVE]),
    .active_i (!soft_reset_bit),
    .status_o (command_progress_flags),
    .echo_o   (legacy_drive_echo)
  );

  // upper address byte, reset while soft reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset_bit)
      cylinder_upper_byte <= RST_CYL_HIGH;
    else if (wr_cyl)
      cylinder_upper_byte <= link.dd;
  end

  // drive/head select, all eight bits stored as written
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset_bit)
      drive_head_select <= RST_DRIVE_HEAD;
    else if (wr_dh)
      drive_head_select <= link.dd;
  end

  // reset and interrupt control; bits 7-4, 3 and 0 are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_reset_bit        <= 1'b0;
      interrupt_disable_bit <= RST_IRQ_OFF;
    end else if (wr_ctl) begin
      soft_reset_bit        <= link.dd[DC_SOFT_RESET];
      interrupt_disable_bit <= link.dd[DC_IRQ_OFF];
    end
  end

  // busy from accepted command until the engine reports done
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset_bit)
      busy_flag <= 1'b0;
    else if (cmd_accept)
      busy_flag <= 1'b1;
    else if (op_done_i)
      busy_flag <= 1'b0;
  end

  // data request: set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset_bit)
      data_request_flag <= 1'b0;
    else if (data_req_set_i)
      data_request_flag <= 1'b1;
    else if (wr_cmd || data_req_clr_i)
      data_request_flag <= 1'b0;
  end

  // corrected data: set wins over new command clear
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset_bit)
      corrected_data_flag <= 1'b0;
    else if (corrected_i)
      corrected_data_flag <= 1'b1;
    else if (cmd_accept)
      corrected_data_flag <= 1'b0;
  end

  // error: failed completion or refused media command
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset_bit)
      error_flag <= 1'b0;
    else if ((op_done_i && op_error_i) || cmd_reject)
      error_flag <= 1'b1;
    else if (cmd_accept)
      error_flag <= 1'b0;
  end

  // interrupt pending: set on completion or refusal, set wins
  always_comb begin
    next_irq_pending = irq_pending;
    if (cmd_accept)
      next_irq_pending = 1'b0;
    if (rd_status && io_mode_i && level_irq_i)
      next_irq_pending = 1'b0;
    if (op_done_i || cmd_reject)
      next_irq_pending = 1'b1;
  end

  // pending state; an alternate status read does not touch it
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_reset_bit)
      irq_pending <= 1'b0;
    else
      irq_pending <= next_irq_pending;
  end

  // interrupt request output, gated by the active-low enable
  always_ff @(posedge clk_i) begin
    if (rst_i)
      link.interrupt_request_n <= 1'b1;
    else
      link.interrupt_request_n <= ~(irq_pending && !interrupt_disable_bit);
  end

  // read data driven in the cycle after the read strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.dev_dd_o    <= 8'h00;
      link.dev_dd_oe_n <= OE_ALL_OFF;
    end else if (rd_status || rd_alt) begin
      link.dev_dd_o    <= command_progress_flags;
      link.dev_dd_oe_n <= OE_ALL_ON;
    end else if (rd_echo) begin
      link.dev_dd_o    <= legacy_drive_echo;
      link.dev_dd_oe_n <= OE_ECHO;
    end else if (link.rd && link.reg_sel == SEL_CYL_HIGH) begin
      link.dev_dd_o    <= cylinder_upper_byte;
      link.dev_dd_oe_n <= OE_ALL_ON;
    end else if (link.rd && link.reg_sel == SEL_DRIVE_HEAD) begin
      link.dev_dd_o    <= drive_head_select;
      link.dev_dd_oe_n <= OE_ALL_ON;
    end else begin
      link.dev_dd_oe_n <= OE_ALL_OFF;
    end
  end

  // command hand-off to the engine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_valid_o <= 1'b0;
      cmd_code_o  <= 8'h00;
    end else begin
      cmd_valid_o <= cmd_accept;
      if (cmd_accept)
        cmd_code_o <= link.dd;
    end
  end

  // addressing parameters for the next transfer
  always_comb begin
    cyl_high_o               = cylinder_upper_byte;
    head_o                   = drive_head_select[DH_HEAD_MSB:0];
    linear_addressing_flag_o = drive_head_select[DH_LINEAR];
    drive_select_bit_o       = drive_head_select[DH_DRIVE];
    soft_reset_bit_o         = soft_reset_bit;
  end

endmodule

// File: logic/tf_flag_pack.sv
// packs progress flags and drive echo bytes
`timescale 1ns/1ps
module tf_flag_pack
  import tf_pkg::*;
#(
  parameter logic DRIVE_NUM = 1'b0
) (
  input  wire logic       busy_i,
  input  wire logic       ready_i,
  input  wire logic       fault_i,
  input  wire logic       seek_i,
  input  wire logic       dreq_i,
  input  wire logic       corrected_data_flag_i,
  input  wire logic       err_i,
  input  wire logic [3:0] head_i,
  input  wire logic       drive_i,
  input  wire logic       active_i,
  output logic      [7:0] status_o,
  output logic      [7:0] echo_o
);
  // progress flags byte
  always_comb begin
    status_o            = 8'h00;
    status_o[BIT_BUSY]  = busy_i;
    status_o[BIT_READY] = ready_i;
    status_o[BIT_FAULT] = fault_i;
    status_o[BIT_SEEK]  = seek_i;
    status_o[BIT_DREQ]  = dreq_i;
    status_o[BIT_CORRECTED] = corrected_data_flag_i;
    status_o[BIT_INDEX] = 1'b0;
    status_o[BIT_ERR]   = err_i;
  end

  // drive echo byte, bit 7 never driven
  always_comb begin
    echo_o = 8'h00;
    echo_o[DA_FLOAT] = 1'b1;
    echo_o[DA_WGATE] = 1'b0;
    echo_o[DA_HEAD_LSB +: 4] = ~head_i;
    echo_o[DA_DS1] = ~(active_i && drive_i && DRIVE_NUM);
    echo_o[DA_DS0] = ~(active_i && !drive_i && !DRIVE_NUM);
  end
endmodule

// File: logic/tf_host.sv
// host end: wishbone slave that runs single task file accesses
`timescale 1ns/1ps
module tf_host
  import tf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  tf_link_if.host          link,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o
);
  typedef enum {IDLE, STROBE, CAPTURE} host_state_t;

  host_state_t state;
  logic [7:0]  read_data;
  logic [7:0]  last_status;
  logic        refused;
  logic        rd_req;
  logic        go;
  logic [3:0]  sel;
  logic [7:0]  wdata;
  logic        cmd_ok;

  assign go    = cyc_i && stb_i && !ack_o && we_i && (adr_i == WB_ACCESS) && sel_i[0];
  assign sel   = dat_i[ACC_SEL_LSB +: 4];
  assign cmd_ok = !last_status[BIT_BUSY] && last_status[BIT_READY];

  // write data with fixed bits forced
  always_comb begin
    wdata = dat_i[ACC_DATA_LSB +: 8];
    if (sel == SEL_DRIVE_HEAD) begin
      wdata[DH_OBS_HI] = 1'b1;
      wdata[DH_OBS_LO] = 1'b1;
    end
    if (sel == SEL_ALT_DEVCTL) begin
      wdata[DC_ONE]  = 1'b1;
      wdata[DC_ZERO] = 1'b0;
    end
  end

  // wishbone answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  // read data mux
  always_ff @(posedge clk_i) begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (adr_i == WB_RESULT)
      dat_o <= {21'h00_0000, refused, !link.interrupt_request_n,
                state != IDLE, read_data};
    else
      dat_o <= 32'h0000_0000;
  end

  // link sequencer: one strobe cycle, one capture cycle for reads
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state             <= IDLE;
      link.reg_sel      <= 4'h0;
      link.rd           <= 1'b0;
      link.wr           <= 1'b0;
      link.host_dd_o    <= 8'h00;
      link.host_dd_oe_n <= 1'b1;
      rd_req            <= 1'b0;
      refused           <= 1'b0;
    end else begin
      case (state)
        IDLE: begin
          if (go) begin
            if (dat_i[ACC_WRITE] && sel == SEL_STATUS_CMD && !cmd_ok) begin
              refused <= 1'b1;
            end else begin
              refused           <= 1'b0;
              state             <= STROBE;
              link.reg_sel      <= sel;
              link.rd           <= !dat_i[ACC_WRITE];
              link.wr           <= dat_i[ACC_WRITE];
              link.host_dd_o    <= wdata;
              link.host_dd_oe_n <= !dat_i[ACC_WRITE];
              rd_req            <= !dat_i[ACC_WRITE];
            end
          end
        end
        STROBE: begin
          link.rd           <= 1'b0;
          link.wr           <= 1'b0;
          link.host_dd_oe_n <= 1'b1;
          state             <= rd_req ? CAPTURE : IDLE;
        end
        CAPTURE: begin
          state <= IDLE;
        end
        default: state <= IDLE;
      endcase
    end
  end

  // captured read byte and last seen progress flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      read_data   <= 8'h00;
      last_status <= RST_LAST_STATUS;
    end else if (state == CAPTURE) begin
      read_data <= link.dd;
      if (link.reg_sel == SEL_DRIVE_ADDR)
        read_data[DA_FLOAT] <= 1'b0;
      if (link.reg_sel == SEL_STATUS_CMD || link.reg_sel == SEL_ALT_DEVCTL)
        last_status <= link.dd;
    end
  end
endmodule

// File: logic/tf_link_if.sv
// task file link between host controller and card end
`timescale 1ns/1ps
interface tf_link_if;
  logic [3:0] reg_sel;
  logic       rd;
  logic       wr;
  logic [7:0] host_dd_o;
  logic       host_dd_oe_n;
  logic [7:0] dev_dd_o;
  logic [7:0] dev_dd_oe_n;
  logic [7:0] dd;
  logic       interrupt_request_n;

  // resolved data wire, undriven bits float high by pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!host_dd_oe_n)
        dd[i] = host_dd_o[i];
      else if (!dev_dd_oe_n[i])
        dd[i] = dev_dd_o[i];
      else
        dd[i] = 1'b1;
    end
  end

  modport dev  (input reg_sel, rd, wr, dd,
                output dev_dd_o, dev_dd_oe_n, interrupt_request_n);
  modport host (input dd, interrupt_request_n,
                output reg_sel, rd, wr, host_dd_o, host_dd_oe_n);
endinterface

// File: logic/tf_pkg.sv
// shared constants and helpers for the task file control registers and their host
package tf_pkg;

  // register select codes on the link (bit 3 marks the control block)
  localparam logic [3:0] SEL_CYL_HIGH   = 4'h5;
  localparam logic [3:0] SEL_DRIVE_HEAD = 4'h6;
  localparam logic [3:0] SEL_STATUS_CMD = 4'h7;
  localparam logic [3:0] SEL_ALT_DEVCTL = 4'hE;
  localparam logic [3:0] SEL_DRIVE_ADDR = 4'hF;

  // progress flag bit positions
  localparam int BIT_BUSY  = 7;
  localparam int BIT_READY = 6;
  localparam int BIT_FAULT = 5;
  localparam int BIT_SEEK  = 4;
  localparam int BIT_DREQ  = 3;
  localparam int BIT_CORRECTED = 2;
  localparam int BIT_INDEX = 1;
  localparam int BIT_ERR   = 0;

  // drive/head fields
  localparam int DH_OBS_HI   = 7;
  localparam int DH_LINEAR   = 6;
  localparam int DH_OBS_LO   = 5;
  localparam int DH_DRIVE    = 4;
  localparam int DH_HEAD_MSB = 3;

  // reset/interrupt control fields
  localparam int DC_ONE  = 3;
  localparam int DC_SOFT_RESET = 2;
  localparam int DC_IRQ_OFF    = 1;
  localparam int DC_ZERO = 0;

  // drive echo fields
  localparam int DA_FLOAT = 7;
  localparam int DA_WGATE = 6;
  localparam int DA_HEAD_LSB = 2;
  localparam int DA_DS1 = 1;
  localparam int DA_DS0 = 0;

  // reset values
  localparam logic [7:0] RST_CYL_HIGH    = 8'h00;
  localparam logic [7:0] RST_DRIVE_HEAD  = 8'h00;
  localparam logic       RST_IRQ_OFF     = 1'b0;
  localparam logic [7:0] RST_LAST_STATUS = 8'h80;
  localparam logic [7:0] OE_ALL_OFF      = 8'hFF;
  localparam logic [7:0] OE_ALL_ON       = 8'h00;
  localparam logic [7:0] OE_ECHO         = 8'h80;

  // host wishbone map
  localparam logic [3:0] WB_ACCESS = 4'h0;
  localparam logic [3:0] WB_RESULT = 4'h4;
  localparam int ACC_SEL_LSB  = 0;
  localparam int ACC_WRITE    = 8;
  localparam int ACC_DATA_LSB = 16;
  localparam int RES_BUSY     = 8;
  localparam int RES_IRQ      = 9;
  localparam int RES_REFUSED  = 10;

  // read, write and seek class commands need ready and seek complete
  function automatic logic is_media_cmd(input logic [7:0] c);
    logic r;
    r = 1'b0;
    case (c)
      8'h20, 8'h21, 8'h22, 8'h23, 8'h30, 8'h31, 8'h32, 8'h33,
      8'h38, 8'h3C, 8'h40, 8'h41, 8'hC4, 8'hC5, 8'hCD: r = 1'b1;
      default: r = (c[7:4] == 4'h7);
    endcase
    return r;
  endfunction

endpackage

// File: tb/test_ata_task_file_control_registers.sv
// self-checking bench joining host end and card end over the task file link
`timescale 1ns/1ps
module test_ata_task_file_control_registers
  import tf_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, ack_o;
  logic [3:0]  adr, head;
  logic [31:0] dat, dat_o, r;
  logic        io_mode, level_irq, ready, seek_done, write_fault, dreq_set, corrected;
  logic        op_done, op_error, cmd_valid, lin_flag, drive_bit, soft_rst_bit;
  logic [7:0]  cmd_code, cyl_high, last_cmd;
  int          err_count, checks, cmd_cnt, cycles;

  // design ends, link and checker
  tf_link_if u_tf_link_if ();
  tf_device #(.DRIVE_NUM(1'b0)) u_tf_device (.clk_i(clk_i), .rst_i(rst_i),
    .link(u_tf_link_if), .io_mode_i(io_mode), .level_irq_i(level_irq), .ready_i(ready),
    .seek_done_i(seek_done), .write_fault_i(write_fault), .data_req_set_i(dreq_set),
    .data_req_clr_i(1'b0), .corrected_i(corrected), .op_done_i(op_done),
    .op_error_i(op_error), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
    .cyl_high_o(cyl_high), .head_o(head), .linear_addressing_flag_o(lin_flag),
    .drive_select_bit_o(drive_bit), .soft_reset_bit_o(soft_rst_bit));
  tf_host u_tf_host (.clk_i(clk_i), .rst_i(rst_i), .link(u_tf_link_if), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o));
  tf_link_properties #(.DRIVE_NUM(1'b0)) u_tf_link_properties (.clk_i(clk_i),
    .rst_i(rst_i), .reg_sel(u_tf_link_if.reg_sel), .rd(u_tf_link_if.rd),
    .wr(u_tf_link_if.wr), .host_dd_o(u_tf_link_if.host_dd_o),
    .host_dd_oe_n(u_tf_link_if.host_dd_oe_n), .dev_dd_o(u_tf_link_if.dev_dd_o),
    .dev_dd_oe_n(u_tf_link_if.dev_dd_oe_n),
    .interrupt_request_n(u_tf_link_if.interrupt_request_n));

  // clock
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // command pulse monitor and hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cmd_valid === 1'b1) begin
      cmd_cnt <= cmd_cnt + 1;
      last_cmd <= cmd_code;
    end
    if (cycles == 20000) begin
      err_count = err_count + 1;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one classic wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // one link access, result word left in r
  task automatic acc(input logic w, input logic [3:0] s, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, WB_ACCESS, {8'h00, d, 7'h00, w, 4'h0, s}, q);
    do begin
      wb(1'b0, WB_RESULT, 32'h0000_0000, r);
    end while (r[RES_BUSY] !== 1'b0);
  endtask

  task automatic cmd(input logic [7:0] c);
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    acc(1'b1, SEL_STATUS_CMD, c);
  endtask

  task automatic finish_op(input logic e);
    @(posedge clk_i);
    op_done <= 1'b1;
    op_error <= e;
    @(posedge clk_i);
    op_done <= 1'b0;
    op_error <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic t_regs();
    acc(1'b0, SEL_CYL_HIGH, 8'h00);
    chk("cyl reset", r[7:0], RST_CYL_HIGH);
    acc(1'b1, SEL_CYL_HIGH, 8'h5A);
    acc(1'b0, SEL_CYL_HIGH, 8'h00);
    chk("cyl byte", r[7:0], 8'h5A);
    chk("cyl out", cyl_high, 8'h5A);
    acc(1'b1, SEL_DRIVE_HEAD, 8'h4B);
    acc(1'b0, SEL_DRIVE_HEAD, 8'h00);
    chk("dh byte", r[7:0], 8'hEB);
    chk("linear", lin_flag, 1'b1);
    chk("head", head, 4'hB);
    acc(1'b1, SEL_DRIVE_HEAD, 8'h13);
    chk("drive", drive_bit, 1'b1);
    chk("chs", lin_flag, 1'b0);
    acc(1'b0, SEL_DRIVE_ADDR, 8'h00);
    chk("echo head", r[6:2], 5'h0C);
    chk("echo drive0", r[0], 1'b1);
    acc(1'b1, SEL_DRIVE_HEAD, 8'h05);
    acc(1'b0, SEL_DRIVE_ADDR, 8'h00);
    chk("echo byte", r[7:0], 8'h2A);
  endtask

  task automatic t_status();
    write_fault <= 1'b1;
    @(posedge clk_i);
    corrected <= 1'b1;
    dreq_set <= 1'b1;
    @(posedge clk_i);
    corrected <= 1'b0;
    dreq_set <= 1'b0;
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    chk("status", r[7:0], 8'h7C);
    acc(1'b0, SEL_ALT_DEVCTL, 8'h00);
    chk("alt status", r[7:0], 8'h7C);
    write_fault <= 1'b0;
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    chk("fault", r[BIT_FAULT], 1'b0);
  endtask

  task automatic t_cmd();
    cmd(8'hEC);
    chk("code", last_cmd, 8'hEC);
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    chk("busy", r[BIT_BUSY], 1'b1);
    cmd(8'hEC);
    chk("refused", r[RES_REFUSED], 1'b1);
    chk("count", cmd_cnt, 1);
    finish_op(1'b0);
    chk("irq on", u_tf_link_if.interrupt_request_n, 1'b0);
    acc(1'b0, SEL_ALT_DEVCTL, 8'h00);
    chk("irq kept", u_tf_link_if.interrupt_request_n, 1'b0);
    chk("irq bit", r[RES_IRQ], 1'b1);
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    chk("dreq", r[BIT_DREQ], 1'b0);
    chk("irq off", u_tf_link_if.interrupt_request_n, 1'b1);
  endtask

  task automatic t_media();
    seek_done <= 1'b0;
    cmd(8'h20);
    chk("no start", cmd_cnt, 1);
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    chk("err set", r[BIT_ERR], 1'b1);
    seek_done <= 1'b1;
    cmd(8'h20);
    chk("start", cmd_cnt, 2);
    finish_op(1'b0);
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    chk("err clear", r[BIT_ERR], 1'b0);
    cmd(8'h70);
    finish_op(1'b1);
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    chk("err fail", r[7:0], 8'h51);
  endtask

  task automatic t_irq();
    acc(1'b1, SEL_ALT_DEVCTL, 8'h02);
    cmd(8'hEC);
    finish_op(1'b0);
    chk("masked", u_tf_link_if.interrupt_request_n, 1'b1);
    acc(1'b1, SEL_ALT_DEVCTL, 8'h00);
    for (int k = 0; k < 2; k++) begin
      io_mode <= k[0];
      level_irq <= ~k[0];
      cmd(8'hEC);
      finish_op(1'b0);
      acc(1'b0, SEL_STATUS_CMD, 8'h00);
      chk("irq held", u_tf_link_if.interrupt_request_n, 1'b0);
    end
    io_mode <= 1'b1;
    level_irq <= 1'b1;
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    chk("irq drop", u_tf_link_if.interrupt_request_n, 1'b1);
  endtask

  task automatic t_soft_rst();
    acc(1'b1, SEL_ALT_DEVCTL, 8'h04);
    chk("soft reset on", soft_rst_bit, 1'b1);
    acc(1'b0, SEL_STATUS_CMD, 8'h00);
    chk("soft reset busy", r[BIT_BUSY], 1'b1);
    acc(1'b1, SEL_CYL_HIGH, 8'h77);
    acc(1'b0, SEL_DRIVE_ADDR, 8'h00);
    chk("echo idle", r[0], 1'b1);
    acc(1'b1, SEL_ALT_DEVCTL, 8'h00);
    chk("soft reset off", soft_rst_bit, 1'b0);
    acc(1'b0, SEL_CYL_HIGH, 8'h00);
    chk("cyl cleared", r[7:0], 8'h00);
    wb(1'b0, 4'h8, 32'h0000_0000, r);
    chk("unmapped", r, 32'h0000_0000);
  endtask

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 4'h0;
    dat = 32'h0000_0000;
    {io_mode, level_irq, ready, seek_done} = 4'hF;
    {write_fault, dreq_set, corrected, op_done, op_error} = 5'h00;
    {err_count, checks, cmd_cnt, cycles} = 128'h0;
    last_cmd = 8'h00;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_status();
    t_cmd();
    t_media();
    t_irq();
    t_soft_rst();
    test_done();
  end
endmodule

// File: tb/tf_link_properties.sv
// concurrent checks on the task file link between host end and card end
`timescale 1ns/1ps
module tf_link_properties
  import tf_pkg::*;
#(
  parameter logic DRIVE_NUM = 1'b0
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] reg_sel,
  input  wire logic       rd,
  input  wire logic       wr,
  input  wire logic [7:0] host_dd_o,
  input  wire logic       host_dd_oe_n,
  input  wire logic [7:0] dev_dd_o,
  input  wire logic [7:0] dev_dd_oe_n,
  input  wire logic       interrupt_request_n
);
  logic [7:0] cyl;
  logic [7:0] dh;
  logic       soft_rst;
  logic       irq_off;
  logic       irq_off_q;
  logic       st_rd;
  logic       echo_rd;

  // read strobes of interest
  assign st_rd   = rd && (reg_sel == SEL_STATUS_CMD || reg_sel == SEL_ALT_DEVCTL);
  assign echo_rd = rd && reg_sel == SEL_DRIVE_ADDR;

  // control byte shadow
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst  <= 1'b0;
      irq_off   <= RST_IRQ_OFF;
      irq_off_q <= RST_IRQ_OFF;
    end else begin
      irq_off_q <= irq_off;
      if (wr && !host_dd_oe_n && reg_sel == SEL_ALT_DEVCTL) begin
        soft_rst <= host_dd_o[DC_SOFT_RESET];
        irq_off  <= host_dd_o[DC_IRQ_OFF];
      end
    end
  end

  // address byte shadows, cleared while soft reset holds
  always_ff @(posedge clk_i) begin
    if (rst_i || soft_rst) begin
      cyl <= RST_CYL_HIGH;
      dh  <= RST_DRIVE_HEAD;
    end else if (wr && !host_dd_oe_n && reg_sel == SEL_CYL_HIGH) begin
      cyl <= host_dd_o;
    end else if (wr && !host_dd_oe_n && reg_sel == SEL_DRIVE_HEAD) begin
      dh <= host_dd_o;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  cyl_read_a: assert property (
    rd && reg_sel == SEL_CYL_HIGH |=> dev_dd_o == cyl && dev_dd_oe_n == OE_ALL_ON)
    else $error("cylinder byte read back wrong");
  dh_read_a: assert property (
    rd && reg_sel == SEL_DRIVE_HEAD |=> dev_dd_o == dh && dev_dd_oe_n == OE_ALL_ON)
    else $error("drive head byte read back wrong");
  busy_soft_rst_a: assert property (
    st_rd && soft_rst |=> dev_dd_o[BIT_BUSY]) else $error("busy missing in soft reset");
  index_zero_a: assert property (
    st_rd |=> !dev_dd_o[BIT_INDEX] && dev_dd_oe_n == OE_ALL_ON)
    else $error("index flag not zero");
  echo_float_a: assert property (
    echo_rd |=> dev_dd_oe_n == OE_ECHO ##1 dev_dd_oe_n == OE_ALL_OFF)
    else $error("echo top bit driven");
  echo_head_a: assert property (
    echo_rd |=> dev_dd_o[5:2] == ~dh[3:0] && !dev_dd_o[DA_WGATE])
    else $error("echo head bits wrong");
  echo_drive_a: assert property (
    echo_rd |=> dev_dd_o[DRIVE_NUM] == (soft_rst || dh[DH_DRIVE] != DRIVE_NUM))
    else $error("echo drive select bit wrong");
  irq_mask_a: assert property (
    irq_off && irq_off_q |-> interrupt_request_n) else $error("masked interrupt asserted");
  idle_float_a: assert property (
    !rd |=> dev_dd_oe_n == OE_ALL_OFF) else $error("data driven without read");
  alt_irq_a: assert property (
    rd && reg_sel == SEL_ALT_DEVCTL && !interrupt_request_n |=> !interrupt_request_n [*2])
    else $error("alternate read dropped interrupt");
endmodule
